/* rtl/ste_tx_err_mon.v */
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ste_defines.vh"

module ste_tx_err_mon #(
  parameter NP          = 2,
  parameter DW          = 32,
  parameter MW          = 2,
  parameter MAX_CAL_LEN = 8'h10
) (
  input  wire               REF_CLK,
  input  wire               RST,
  input  wire               HSEL,
  input  wire [7:0]         HADDR,
  input  wire [1:0]         HTRANS,
  input  wire               HWRITE,
  input  wire [2:0]         HSIZE,
  input  wire [31:0]        HWDATA,
  input  wire               HREADY,
  output reg                HREADYOUT,
  output reg                HRESP,
  output reg  [31:0]        HRDATA,
  input  wire               STATUS_CLOCK,
  input  wire [1:0]         STATUS_DATA,
  input  wire               TX_BURST_BOUNDARY,
  input  wire               TX_EOP,
  output reg                STATUS_LINK_LOCKED,
  output reg                STATUS_PARITY_ERROR_PULSE,
  output reg                STATUS_FRAMING_ERROR_PULSE,
  output reg  [2*NP-1:0]    PORT_STATUS,
  output reg                PORT_STATUS_UPDATE,
  output reg                CREDIT_REVOKE,
  output reg                TX_TRAINING,
  input  wire [NP-1:0]      WR_ENA,
  input  wire [NP-1:0]      WR_SOP,
  input  wire [NP-1:0]      WR_EOP,
  input  wire [NP-1:0]      WR_ERR,
  input  wire [NP*MW-1:0]   WR_MTY,
  input  wire [NP*DW-1:0]   WR_DAT,
  input  wire [NP-1:0]      FIFO_FULL,
  input  wire [NP-1:0]      FIFO_EMPTY,
  input  wire [NP*16-1:0]   FIFO_FREE,
  output wire [NP-1:0]      FIFO_WR,
  output wire [NP-1:0]      FIFO_SOP,
  output wire [NP-1:0]      FIFO_EOP,
  output wire [NP-1:0]      FIFO_ERR,
  output wire [NP*MW-1:0]   FIFO_MTY,
  output wire [NP*DW-1:0]   FIFO_DAT,
  output wire [NP-1:0]      MISSING_SOP_FLAG,
  output wire [NP-1:0]      MISSING_EOP_FLAG,
  output wire [NP-1:0]      FIFO_OVERFLOW_FLAG,
  output wire [NP-1:0]      WRITE_SPACE_AVAILABLE
);

  // ----------------------------------------------------------------
  // register file over AHB-Lite
  // ----------------------------------------------------------------
  reg  [3:0]  ctrl_r;
  reg  [3:0]  lock_good_count_r;
  reg  [3:0]  lock_bad_count_r;
  reg  [7:0]  cal_len_r;
  reg  [7:0]  cal_m_r;
  reg  [15:0] fth_r;
  reg         wr_pend_r;
  reg  [7:0]  wr_addr_r;
  reg         resync_r;
  reg  [2:0]  state_r;
  reg  [2*NP-1:0] port_stat_buf_r;
  wire        misconfig;
  wire        take;

  assign take      = HSEL && HREADY && HTRANS[1];
  assign misconfig = (cal_len_r == 8'h00) || (cal_m_r == 8'h00) ||
                     (cal_len_r > MAX_CAL_LEN);

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      HREADYOUT         <= 1'b1;
      HRESP             <= 1'b0;
      HRDATA            <= 32'h00000000;
      wr_pend_r         <= 1'b0;
      wr_addr_r         <= 8'h00;
      ctrl_r            <= `STE_CTRL_RST;
      lock_good_count_r <= `STE_GOOD_RST;
      lock_bad_count_r  <= `STE_BAD_RST;
      cal_len_r         <= `STE_CALLEN_RST;
      cal_m_r           <= `STE_CALM_RST;
      fth_r             <= `STE_FTH_RST;
      resync_r          <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      wr_pend_r <= take && HWRITE;
      resync_r  <= 1'b0;
      if (take)
        wr_addr_r <= HADDR;
      if (wr_pend_r) begin
        case (wr_addr_r)
          `STE_REG_CTRL: begin
            ctrl_r   <= {1'b0, HWDATA[2:0]};
            resync_r <= HWDATA[`STE_CTRL_RESYNC];
          end
          `STE_REG_THRESH: begin
            lock_good_count_r <= HWDATA[3:0];
            lock_bad_count_r  <= HWDATA[7:4];
          end
          `STE_REG_CAL: begin
            cal_len_r <= HWDATA[7:0];
            cal_m_r   <= HWDATA[15:8];
          end
          `STE_REG_FTH: fth_r <= HWDATA[15:0];
          default: ;
        endcase
      end
      if (take && !HWRITE) begin
        case (HADDR)
          `STE_REG_CTRL:    HRDATA <= {28'h0000000, ctrl_r};
          `STE_REG_THRESH:  HRDATA <= {24'h000000, lock_bad_count_r,
                                       lock_good_count_r};
          `STE_REG_CAL:     HRDATA <= {16'h0000, cal_m_r, cal_len_r};
          `STE_REG_FTH:     HRDATA <= {16'h0000, fth_r};
          `STE_REG_STATUS:  HRDATA <= {8'h00,
                                       {{(8-NP){1'b0}},
                                        WRITE_SPACE_AVAILABLE},
                                       {{(8-NP){1'b0}},
                                        FIFO_OVERFLOW_FLAG},
                                       3'h0, misconfig, state_r,
                                       STATUS_LINK_LOCKED};
          `STE_REG_PORTSTAT: HRDATA <= {{(32-2*NP){1'b0}}, PORT_STATUS};
          default:          HRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // status channel sampling
  // ----------------------------------------------------------------
  // clock is flopped three times (the third for edge detection), data twice; the data settle half a
  // status period before the rising edge, so the skew is harmless
  reg       sclk_s1_r;
  reg       sclk_s2_r;
  reg       sclk_s3_r;
  reg [1:0] sdat_s1_r;
  reg [1:0] sdat_s2_r;
  wire      srise;
  wire [1:0] w;

  assign srise = sclk_s2_r && !sclk_s3_r;
  assign w     = sdat_s2_r;

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      sdat_s1_r <= 2'h0;
      sdat_s2_r <= 2'h0;
    end else begin
      sclk_s1_r <= STATUS_CLOCK;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      sdat_s1_r <= STATUS_DATA;
      sdat_s2_r <= sdat_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // status sequence decoder and lock control
  // ----------------------------------------------------------------
  reg  [15:0] slot_r;
  reg  [1:0]  dip_r;
  reg  [4:0]  frun_r;
  reg         seq_err_r;
  reg  [3:0]  good_r;
  reg  [3:0]  bad_r;
  reg         frm_err;
  reg         dip_err;
  reg         seq_end;
  reg  [2:0]  state_nxt;
  reg  [7:0]  since_r;
  reg  [7:0]  per_r;
  wire [15:0] slots;
  wire [1:0]  dip_nxt;
  wire        pessim;
  wire [3:0]  good_th;
  wire [3:0]  bad_th;

  assign slots   = cal_len_r * cal_m_r;
  assign dip_nxt = {dip_r[0], dip_r[1]} ^ w;
  assign pessim  = ctrl_r[`STE_CTRL_PESSIM];
  assign good_th = (lock_good_count_r == 4'h0) ? 4'h1 : lock_good_count_r;
  assign bad_th  = (lock_bad_count_r == 4'h0) ? 4'h1 : lock_bad_count_r;

  always @* begin
    frm_err   = 1'b0;
    dip_err   = 1'b0;
    seq_end   = 1'b0;
    state_nxt = state_r;
    case (state_r)
      `STE_S_DISABLED: begin
        if (w == `STE_W_FRAME)
          state_nxt = `STE_S_FRAME;
      end
      `STE_S_FRAME: begin
        if (w == `STE_W_FRAME) begin
          if (frun_r == `STE_FRAME_RUN_MAX) begin
            seq_end   = 1'b1;
            state_nxt = `STE_S_DISABLED;
          end
        end else if (ctrl_r[`STE_CTRL_HITLESS]) begin
          if (w != `STE_W_SEL0 && w != `STE_W_SEL1) begin
            frm_err   = 1'b1;
            seq_end   = 1'b1;
            state_nxt = `STE_S_DISABLED;
          end else begin
            state_nxt = `STE_S_CAL;
          end
        end else begin
          state_nxt = (slots == 16'h0001) ? `STE_S_DIP : `STE_S_CAL;
        end
      end
      `STE_S_CAL: begin
        if (w == `STE_W_FRAME) begin
          frm_err   = 1'b1;
          seq_end   = 1'b1;
          state_nxt = `STE_S_DISABLED;
        end else if (slot_r + 16'h0001 >= slots) begin
          state_nxt = `STE_S_DIP;
        end
      end
      `STE_S_DIP: begin
        dip_err   = (w != ~dip_r);
        seq_end   = 1'b1;
        state_nxt = `STE_S_SELECT;
      end
      `STE_S_SELECT: begin
        // after dip-2 the next word has to be framing again
        if (w == `STE_W_FRAME) begin
          state_nxt = `STE_S_FRAME;
        end else begin
          frm_err   = 1'b1;
          state_nxt = `STE_S_DISABLED;
        end
      end
      default: state_nxt = `STE_S_DISABLED;
    endcase
  end

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_r                    <= `STE_S_DISABLED;
      slot_r                     <= 16'h0000;
      dip_r                      <= 2'h3;
      frun_r                     <= 5'h00;
      seq_err_r                  <= 1'b0;
      good_r                     <= 4'h0;
      bad_r                      <= 4'h0;
      port_stat_buf_r            <= {2*NP{1'b0}};
      STATUS_LINK_LOCKED         <= 1'b0;
      STATUS_PARITY_ERROR_PULSE  <= 1'b0;
      STATUS_FRAMING_ERROR_PULSE <= 1'b0;
      PORT_STATUS                <= {2*NP{1'b0}};
      PORT_STATUS_UPDATE         <= 1'b0;
      CREDIT_REVOKE              <= 1'b0;
      TX_TRAINING                <= 1'b1;
      since_r                    <= 8'h00;
      per_r                      <= 8'hFF;
    end else begin
      PORT_STATUS_UPDATE <= 1'b0;
      CREDIT_REVOKE      <= 1'b0;
      // a stopped status clock must not stretch a pulse past one period
      since_r <= srise ? 8'h00 : since_r + {7'h00, since_r != 8'hFF};
      if (srise)
        per_r <= since_r + 8'h01;
      else if (since_r + 8'h01 == per_r) begin
        STATUS_PARITY_ERROR_PULSE  <= 1'b0;
        STATUS_FRAMING_ERROR_PULSE <= 1'b0;
      end
      if (STATUS_LINK_LOCKED)
        TX_TRAINING <= 1'b0;
      else if (TX_BURST_BOUNDARY || TX_EOP)
        TX_TRAINING <= 1'b1;
      if (resync_r || misconfig) begin
        state_r <= `STE_S_DISABLED;
        good_r  <= 4'h0;
        bad_r   <= 4'h0;
        if (STATUS_LINK_LOCKED)
          CREDIT_REVOKE <= 1'b1;
        STATUS_LINK_LOCKED <= 1'b0;
      end else if (srise) begin
        state_r <= state_nxt;
        // flags hold from this edge to the next: one status period
        STATUS_FRAMING_ERROR_PULSE <= frm_err;
        STATUS_PARITY_ERROR_PULSE  <= dip_err |
                                      (frm_err & STATUS_LINK_LOCKED);
        frun_r <= (w == `STE_W_FRAME && frun_r != `STE_FRAME_RUN_MAX) ?
                  frun_r + 5'h01 : ((w == `STE_W_FRAME) ? frun_r : 5'h00);
        if (state_r == `STE_S_FRAME && state_nxt != `STE_S_FRAME) begin
          slot_r    <= {15'h0000, !ctrl_r[`STE_CTRL_HITLESS]};
          dip_r     <= {1'b1, 1'b1} ^ w;
          seq_err_r <= 1'b0;
        end else if (state_r == `STE_S_CAL) begin
          slot_r <= slot_r + 16'h0001;
          dip_r  <= dip_nxt;
        end
        // slots landing on a port index carry that port's status
        if ((state_r == `STE_S_CAL ||
             (state_r == `STE_S_FRAME && state_nxt != `STE_S_FRAME &&
              !ctrl_r[`STE_CTRL_HITLESS])) &&
            w != `STE_W_FRAME) begin : slot_upd
          integer k;
          for (k = 0; k < NP; k = k + 1) begin
            if (slot_r == k[15:0] && state_r == `STE_S_CAL ||
                k == 0 && state_r == `STE_S_FRAME) begin
              port_stat_buf_r[2*k +: 2] <= w;
              if (!pessim && STATUS_LINK_LOCKED) begin
                PORT_STATUS[2*k +: 2] <= w;
                PORT_STATUS_UPDATE    <= 1'b1;
              end
            end
          end
        end
        if (seq_end) begin
          if (!(frm_err || dip_err || seq_err_r) &&
              state_r == `STE_S_DIP) begin
            bad_r <= 4'h0;
            if (!STATUS_LINK_LOCKED) begin
              if (good_r + 4'h1 >= good_th) begin
                STATUS_LINK_LOCKED <= 1'b1;
                good_r             <= 4'h0;
              end else begin
                good_r <= good_r + 4'h1;
              end
            end else if (pessim) begin
              PORT_STATUS        <= port_stat_buf_r;
              PORT_STATUS_UPDATE <= 1'b1;
            end
          end else begin
            good_r <= 4'h0;
            if (STATUS_LINK_LOCKED) begin
              if (bad_r + 4'h1 >= bad_th ||
                  state_r == `STE_S_FRAME) begin
                // buffered packets stay in place; only credits go
                STATUS_LINK_LOCKED <= 1'b0;
                CREDIT_REVOKE      <= 1'b1;
                state_r            <= `STE_S_DISABLED;
                bad_r              <= 4'h0;
              end else begin
                bad_r <= bad_r + 4'h1;
              end
            end
          end
        end
        if (frm_err && !seq_end)
          seq_err_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-port write checkers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : port
      ste_wr_chk #(
        .DW (DW),
        .MW (MW)
      ) u_chk (
        .clk                   (REF_CLK),
        .rst                   (RST),
        .check_en              (ctrl_r[`STE_CTRL_CHKEN]),
        .fth                   (fth_r),
        .wr_ena                (WR_ENA[g]),
        .wr_sop                (WR_SOP[g]),
        .wr_eop                (WR_EOP[g]),
        .wr_err                (WR_ERR[g]),
        .wr_mty                (WR_MTY[g*MW +: MW]),
        .wr_dat                (WR_DAT[g*DW +: DW]),
        .fifo_full             (FIFO_FULL[g]),
        .fifo_empty            (FIFO_EMPTY[g]),
        .fifo_free             (FIFO_FREE[g*16 +: 16]),
        .f_wr                  (FIFO_WR[g]),
        .f_sop                 (FIFO_SOP[g]),
        .f_eop                 (FIFO_EOP[g]),
        .f_err                 (FIFO_ERR[g]),
        .f_mty                 (FIFO_MTY[g*MW +: MW]),
        .f_dat                 (FIFO_DAT[g*DW +: DW]),
        .missing_sop_flag      (MISSING_SOP_FLAG[g]),
        .missing_eop_flag      (MISSING_EOP_FLAG[g]),
        .fifo_overflow_flag    (FIFO_OVERFLOW_FLAG[g]),
        .write_space_available (WRITE_SPACE_AVAILABLE[g])
      );
    end
  endgenerate

endmodule
`default_nettype wire

/* rtl/ste_defines.vh */
`ifndef STE_DEFINES_VH
`define STE_DEFINES_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define STE_REG_CTRL      8'h00
`define STE_REG_THRESH    8'h04
`define STE_REG_CAL       8'h08
`define STE_REG_FTH       8'h0C
`define STE_REG_STATUS    8'h10
`define STE_REG_PORTSTAT  8'h14

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define STE_CTRL_PESSIM   0
`define STE_CTRL_HITLESS  1
`define STE_CTRL_CHKEN    2
`define STE_CTRL_RESYNC   3
`define STE_CTRL_RST      4'h5
`define STE_GOOD_RST      4'h4
`define STE_BAD_RST       4'h4
`define STE_CALLEN_RST    8'h04
`define STE_CALM_RST      8'h01
`define STE_FTH_RST       16'h0040

// ----------------------------------------------------------------
// status words, states, timing
// ----------------------------------------------------------------
`define STE_W_FRAME       2'h3
`define STE_W_SEL0        2'h1
`define STE_W_SEL1        2'h2
`define STE_S_DISABLED    3'h0
`define STE_S_FRAME       3'h1
`define STE_S_SELECT      3'h2
`define STE_S_CAL         3'h3
`define STE_S_DIP         3'h4
`define STE_FRAME_RUN_MAX 5'h10
`define STE_DROP_NONE     2'h0
`define STE_DROP_TO_SOP   2'h1
`define STE_DROP_TO_EOP   2'h2

`endif

/* rtl/ste_wr_chk.v */
`timescale 1ns/1ps
`default_nettype none
`include "ste_defines.vh"

module ste_wr_chk #(
  parameter DW = 32,
  parameter MW = 2
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          check_en,
  input  wire [15:0]   fth,
  input  wire          wr_ena,
  input  wire          wr_sop,
  input  wire          wr_eop,
  input  wire          wr_err,
  input  wire [MW-1:0] wr_mty,
  input  wire [DW-1:0] wr_dat,
  input  wire          fifo_full,
  input  wire          fifo_empty,
  input  wire [15:0]   fifo_free,
  output reg           f_wr,
  output reg           f_sop,
  output reg           f_eop,
  output reg           f_err,
  output reg  [MW-1:0] f_mty,
  output reg  [DW-1:0] f_dat,
  output reg           missing_sop_flag,
  output reg           missing_eop_flag,
  output reg           fifo_overflow_flag,
  output reg           write_space_available
);

  reg       open_r;
  reg [1:0] drop_r;

  // ----------------------------------------------------------------
  // packet checker, same clock as the user write port
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      open_r                <= 1'b0;
      drop_r                <= `STE_DROP_NONE;
      f_wr                  <= 1'b0;
      f_sop                 <= 1'b0;
      f_eop                 <= 1'b0;
      f_err                 <= 1'b0;
      f_mty                 <= {MW{1'b0}};
      f_dat                 <= {DW{1'b0}};
      missing_sop_flag      <= 1'b0;
      missing_eop_flag      <= 1'b0;
      fifo_overflow_flag    <= 1'b0;
      write_space_available <= 1'b0;
    end else begin
      f_wr             <= 1'b0;
      missing_sop_flag <= 1'b0;
      missing_eop_flag <= 1'b0;
      f_dat            <= wr_dat;
      f_mty            <= wr_mty;
      f_sop            <= wr_sop;
      f_eop            <= wr_eop;
      f_err            <= wr_err;
      // reading side keeps draining; flag drops only when empty
      if (fifo_overflow_flag && fifo_empty)
        fifo_overflow_flag <= 1'b0;
      write_space_available <= !fifo_overflow_flag &&
                               !(fifo_overflow_flag == 1'b0 && wr_ena &&
                                 fifo_full) &&
                               (fifo_free >= fth);
      if (wr_ena && !fifo_overflow_flag) begin
        if (fifo_full) begin
          // one spare entry is reserved for the truncation word
          fifo_overflow_flag    <= 1'b1;
          write_space_available <= 1'b0;
          if (open_r) begin
            f_wr   <= 1'b1;
            f_sop  <= 1'b0;
            f_eop  <= 1'b1;
            f_err  <= 1'b1;
            f_mty  <= {MW{1'b0}};
            open_r <= 1'b0;
            drop_r <= `STE_DROP_TO_SOP;
          end
        end else if (!check_en) begin
          f_wr   <= 1'b1;
          open_r <= wr_eop ? 1'b0 : (wr_sop | open_r);
        end else if (drop_r == `STE_DROP_TO_EOP) begin
          if (wr_eop)
            drop_r <= `STE_DROP_NONE;
        end else if (drop_r == `STE_DROP_TO_SOP && !wr_sop) begin
          drop_r <= `STE_DROP_TO_SOP;
        end else if (wr_sop && open_r) begin
          missing_eop_flag <= 1'b1;
          f_wr   <= 1'b1;
          f_sop  <= 1'b0;
          f_eop  <= 1'b1;
          f_err  <= 1'b1;
          open_r <= 1'b0;
          drop_r <= `STE_DROP_TO_EOP;
        end else if (!wr_sop && !open_r) begin
          missing_sop_flag <= 1'b1;
          drop_r <= `STE_DROP_TO_SOP;
        end else if (!wr_eop && wr_mty != {MW{1'b0}}) begin
          missing_eop_flag <= 1'b1;
          f_wr   <= 1'b1;
          f_eop  <= 1'b1;
          f_err  <= 1'b1;
          open_r <= 1'b0;
          drop_r <= `STE_DROP_TO_SOP;
        end else begin
          f_wr   <= 1'b1;
          open_r <= !wr_eop;
          drop_r <= `STE_DROP_NONE;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* test/ste_tx_err_mon_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ste_tx_err_mon_asserts #(
  parameter NP = 2
) (
  input wire logic          REF_CLK,
  input wire logic          RST,
  input wire logic          TX_EOP,
  input wire logic          STATUS_LINK_LOCKED,
  input wire logic          STATUS_PARITY_ERROR_PULSE,
  input wire logic          STATUS_FRAMING_ERROR_PULSE,
  input wire logic          CREDIT_REVOKE,
  input wire logic          TX_TRAINING,
  input wire logic [NP-1:0] WR_ENA,
  input wire logic [NP-1:0] WR_SOP,
  input wire logic [NP-1:0] FIFO_WR,
  input wire logic [NP-1:0] MISSING_SOP_FLAG,
  input wire logic [NP-1:0] MISSING_EOP_FLAG,
  input wire logic [NP-1:0] FIFO_OVERFLOW_FLAG,
  input wire logic [NP-1:0] WRITE_SPACE_AVAILABLE
);
  // ----------------
  // port 0 and status link
  // ----------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  chk_msop_cause: assert property (MISSING_SOP_FLAG[0] |->
    $past(WR_ENA[0]) && !$past(WR_SOP[0])) else $error("stray sop flag");
  chk_meop_pulse: assert property (MISSING_EOP_FLAG[0] |->
    $past(WR_ENA[0]) ##1 !MISSING_EOP_FLAG[0]) else $error("bad eop flag");
  chk_ovf_reject: assert property (FIFO_OVERFLOW_FLAG[0] [*3] |->
    !FIFO_WR[0]) else $error("write during overflow");
  chk_ovf_space: assert property (FIFO_OVERFLOW_FLAG[0] &&
    $past(FIFO_OVERFLOW_FLAG[0]) |-> !WRITE_SPACE_AVAILABLE[0])
    else $error("space shown while flushing");
  chk_unlock_revoke: assert property ($fell(STATUS_LINK_LOCKED) |->
    ##[0:2] CREDIT_REVOKE) else $error("no revoke on unlock");
  chk_train_stop: assert property (!STATUS_LINK_LOCKED && TX_EOP |->
    ##[0:4] TX_TRAINING) else $error("no training after unlock");
  chk_par_width: assert property ($rose(STATUS_PARITY_ERROR_PULSE) |->
    STATUS_PARITY_ERROR_PULSE [*7] ##[1:3] !STATUS_PARITY_ERROR_PULSE)
    else $error("parity pulse width");
  chk_frm_width: assert property ($rose(STATUS_FRAMING_ERROR_PULSE) |->
    STATUS_FRAMING_ERROR_PULSE [*7] ##[1:3] !STATUS_FRAMING_ERROR_PULSE)
    else $error("framing pulse width");
endmodule
bind ste_tx_err_mon ste_tx_err_mon_asserts #(.NP(NP)) u_chk (.*);
`default_nettype wire

/* test/ste_stat_src.sv */
`timescale 1ns/1ps
`default_nettype none
module ste_stat_src (
  output logic       sclk,
  output logic [1:0] sdat
);
  logic [1:0] acc;
  initial begin
    sclk = 1'b0;
    sdat = 2'h3;
  end
  // ----------------
  // status words
  // ----------------
  // data moves while the clock is low so the rising edge sees it settled
  task automatic word(input logic [1:0] w);
    sdat = w;
    #40 sclk = 1'b1;
    #40 sclk = 1'b0;
  endtask
  // clock stands still between sequences; bad corrupts the parity word
  task automatic seq(input logic [1:0] lead, input logic [7:0] s,
                     input logic bad);
    word(lead);
    word(2'h3);
    for (int i = 0; i < 4; i++) begin
      acc = (i == 0) ? 2'h3 ^ s[1:0] : {acc[0], acc[1]} ^ s[2*i+:2];
      word(s[2*i+:2]);
    end
    word(~acc ^ {1'b0, bad});
  endtask
endmodule
`default_nettype wire

/* test/ste_tx_err_mon_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ste_tx_err_mon_tb_top;
  logic REF_CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, HREADY, TX_EOP;
  logic STATUS_CLOCK, TX_BURST_BOUNDARY, STATUS_LINK_LOCKED, TX_TRAINING;
  logic STATUS_PARITY_ERROR_PULSE, STATUS_FRAMING_ERROR_PULSE;
  logic PORT_STATUS_UPDATE, CREDIT_REVOKE;
  logic [1:0] HTRANS, STATUS_DATA, WR_ENA, WR_SOP, WR_EOP, WR_ERR, pq;
  logic [1:0] FIFO_FULL, FIFO_EMPTY, FIFO_WR, FIFO_SOP, FIFO_EOP, FIFO_ERR;
  logic [1:0] MISSING_SOP_FLAG, MISSING_EOP_FLAG, FIFO_OVERFLOW_FLAG;
  logic [1:0] WRITE_SPACE_AVAILABLE;
  logic [2:0] HSIZE;
  logic [3:0] WR_MTY, FIFO_MTY, PORT_STATUS;
  logic [7:0] HADDR;
  logic [31:0] HWDATA, HRDATA, FIFO_FREE, lf, rd;
  logic [63:0] WR_DAT, FIFO_DAT;
  int mismatches, n_checks, cyc, npar, nfrm, nrev, st;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
  logic [31:0] rv [5] = '{32'h5, 32'h44, 32'h104, 32'h40, 32'h0};
  logic [3:0] wv [9] = '{4'h0, 4'h8, 4'h0, 4'h8, 4'h0, 4'h4, 4'h8, 4'h1,
                         4'hC};
  assign HREADY = HREADYOUT;
  ste_tx_err_mon dut (.*);
  ste_stat_src src (.sclk(STATUS_CLOCK), .sdat(STATUS_DATA));
  // ----------------
  // helpers
  // ----------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [63:0] seen, exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    {HSEL, HTRANS, HADDR, HWRITE} <= {3'h6, a, w};
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    {HSEL, HTRANS, HWDATA} <= {3'h0, d};
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask
  // bench model of the write checker on port 0: 0 idle, 1 open, 2 drop
  task automatic wr(input logic s, e, input logic [1:0] m);
    logic xw, xs, xe;
    logic [31:0] d;
    {xw, xs, xe, d} = {3'h0, lf};
    {WR_ENA[0], WR_SOP[0], WR_EOP[0], WR_MTY[1:0], WR_DAT[31:0]} <=
      {1'b1, s, e, m, d};
    case (st)
      0: {xw, xs, st} = {s, !s, 31'h0, s && !e};
      1: if (s || (m != 2'h0 && !e)) {xw, xe, st} = {2'h3, 30'h0, s, 1'b0};
         else {xw, st} = {1'b1, 31'h0, !e};
      default: st = e ? 0 : 2;
    endcase
    tick(1);
    chk({FIFO_WR[0], MISSING_SOP_FLAG[0]}, {xw, xs}, "wr_msop");
    chk(MISSING_EOP_FLAG[0], xe, "meop");
    if (xw) chk({FIFO_SOP[0], FIFO_EOP[0], FIFO_ERR[0]},
                {s && !xe, e || xe, xe}, "marks");
    if (xw && !xe) chk(FIFO_DAT[31:0], d, "data");
    WR_ENA[0] <= 1'b0;
    tick(1);
  endtask
  task automatic sq(input logic [1:0] lead, input logic [7:0] s,
                    input logic bad);
    src.seq(lead, s, bad);
    tick(4);
  endtask
  // ----------------
  // clock, random lines, monitors, timeout
  // ----------------
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    lf <= lfsr(lf);
    {TX_EOP, TX_BURST_BOUNDARY} <= {lf[0], lf[7]};
    pq <= {STATUS_FRAMING_ERROR_PULSE, STATUS_PARITY_ERROR_PULSE};
    npar <= npar + (STATUS_PARITY_ERROR_PULSE && !pq[0]);
    nfrm <= nfrm + (STATUS_FRAMING_ERROR_PULSE && !pq[1]);
    nrev <= nrev + CREDIT_REVOKE;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  // ----------------
  // main sequence
  // ----------------
  initial begin
    {RST, lf, HSIZE, FIFO_FREE, FIFO_EMPTY} = {1'b1, 32'h548A, 3'h2, 34'h3FFFFFFFF};
    {HSEL, HWRITE, HTRANS, HADDR, HWDATA, pq, TX_EOP} = '0;
    {WR_ENA, WR_SOP, WR_EOP, WR_ERR, WR_MTY, WR_DAT, FIFO_FULL} = '0;
    TX_BURST_BOUNDARY = 1'b0;
    repeat (8) @(posedge REF_CLK);
    RST <= 1'b0;
    foreach (ra[i]) begin
      ahb(1'b0, ra[i], 32'h0);
      chk({HRESP, rd}, rv[i], "reg");
    end
    ahb(1'b1, 8'h04, 32'h23);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h23, "thresh");
    foreach (wv[i]) wr(wv[i][3], wv[i][2], wv[i][1:0]);
    FIFO_FREE[15:0] <= 16'h003F;
    tick(3);
    chk(WRITE_SPACE_AVAILABLE[0], 1'b0, "space");
    FIFO_FREE[15:0] <= 16'h0040;
    tick(3);
    chk(WRITE_SPACE_AVAILABLE[0], 1'b1, "space");
    {FIFO_FULL[0], FIFO_EMPTY[0], WR_ENA[0], WR_SOP[0]} <= 4'hB;
    tick(5);
    FIFO_FULL[0] <= 1'b0;
    tick(3);
    chk({FIFO_OVERFLOW_FLAG[0], WRITE_SPACE_AVAILABLE[0]}, 2'h2, "ovf");
    {WR_ENA[0], FIFO_EMPTY[0]} <= 2'h1;
    tick(3);
    chk({FIFO_OVERFLOW_FLAG[0], WRITE_SPACE_AVAILABLE[0]}, 2'h1, "drain");
    for (int i = 1; i < 5; i++) begin
      sq(2'h3, i < 4 ? 8'h09 : 8'h06, 1'b0);
      chk(STATUS_LINK_LOCKED, i > 2, "lock");
    end
    chk({PORT_STATUS, TX_TRAINING}, 5'h0C, "status");
    sq(2'h1, 8'h06, 1'b0);
    chk(nfrm, 1, "frm");
    st = npar;
    sq(2'h3, 8'h00, 1'b1);
    chk(npar, st + 1, "par");
    chk({STATUS_LINK_LOCKED, PORT_STATUS}, 5'h16, "hold");
    sq(2'h3, 8'h00, 1'b1);
    chk({STATUS_LINK_LOCKED, nrev[1:0]}, 3'h1, "unlock");
    tick(20);
    chk(TX_TRAINING, 1'b1, "train");
    stop_test();
  end
endmodule
`default_nettype wire
